/* data_eeprom_access_control.sv */
// Purpose: Register-driven byte/page read, erase and write of a data EEPROM.
// Assumes: APB slave, one wait state on every access; software keeps its sequences.
// Notes: Erase and write cycle lengths are parameters so a bench can shorten them.
// How it works
// RL1 - Select 0: erase 3.2 ms, write 2.2 ms
// RL2 - Select 1: erase 3.7 ms, write 3.0 ms
// RL3 - Erase start needs erase enable already set
// RL4 - Erase end clears erase start and enable
// RL5 - Mode bit picks byte or 16-byte page
// RL6 - Write start needs write enable already set
// RL7 - Write end clears write start and enable
// RL8 - Read start needs read enable; self-clears
// RL9 - No array read while read disabled
// RL10 - Software sets one enable/start bit per write
// RL11 - Byte read lands and stays in data
// RL12 - Page read: load, increment, then clear start
// RL13 - Page bits fixed; low nibble saturates at F
// RL14 - Buffer cleared on reset and enable fall
// RL15 - Page data writes tag address and advance
// RL16 - Software sets enable then start back to back
// RL17 - Tagged bytes read zero after page erase
// RL18 - Internal timer; poll start bit or flag
// RL19 - Software masks interrupts around activation
// RL20 - Software leaves registers alone while cycle runs
// RL21 - Cycle end sets completion flag; software clears
// RL22 - Byte write replaces the addressed byte
// RL23 - 10-bit address from low and high registers
// RL24 - Starts ignored while any cycle is busy
`timescale 1ns/1ns
module data_eeprom_access_control #(
   parameter int unsigned ERASE_CYC0 = eeprom_pkg::ERASE_CYC0,
   parameter int unsigned WRITE_CYC0 = eeprom_pkg::WRITE_CYC0,
   parameter int unsigned ERASE_CYC1 = eeprom_pkg::ERASE_CYC1,
   parameter int unsigned WRITE_CYC1 = eeprom_pkg::WRITE_CYC1
) (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // APB slave
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Completion flag level
   output logic completion_irq_flag
);
   import eeprom_pkg::*;
   state_type state_q;
   logic [7:0] data_q, addr_low_q, arr_wdata, arr_rdata;
   logic time_sel_q, mode_q, is_erase_q, flag_q, pready_q, pslverr_q, arr_we;
   logic erase_en_q, erase_go_q, write_en_q, write_go_q, read_en_q, read_go_q;
   logic erase_en_prev_q, write_en_prev_q;
   logic [1:0] addr_high_q;
   logic [31:0] timer_q, prdata_q, rd_word;
   logic [3:0] idx_q;
   logic [15:0] tag_q;
   logic [7:0] page_buf_q [PAGE_BYTES];
   logic [ADDR_W-1:0] arr_addr;

   function automatic logic mapped(input logic [11:0] a);
      return (a == OFS_DATA) || (a == OFS_CTRL) || (a == OFS_ADDR_LOW) ||
         (a == OFS_ADDR_HIGH) || (a == OFS_STATUS);
   endfunction : mapped
   // Cycle length minus one, as loaded into the down-counter
   function automatic logic [31:0] pick_cycles(input logic erase, input logic sel);
      int unsigned n;
      n = erase ? (sel ? ERASE_CYC1 : ERASE_CYC0) : (sel ? WRITE_CYC1 : WRITE_CYC0);
      return 32'(n - 1);
   endfunction : pick_cycles
   function automatic logic [3:0] sat_inc(input logic [3:0] v);
      return (v == LOW_NIBBLE_MAX) ? LOW_NIBBLE_MAX : 4'(v + 4'h1);
   endfunction : sat_inc

   // Bus decode; a write takes effect on the edge where pready is seen high
   wire acc = psel & penable & pready_q;
   wire wr = acc & pwrite & pstrb[0];
   wire wr_data = wr && (paddr == OFS_DATA);
   wire wr_ctrl = wr && (paddr == OFS_CTRL);
   wire wr_alow = wr && (paddr == OFS_ADDR_LOW);
   wire wr_ahigh = wr && (paddr == OFS_ADDR_HIGH);
   wire wr_sts = wr && (paddr == OFS_STATUS);
   wire busy = (state_q != ST_IDLE);

   // Enables are checked at their old value, so setting both in one write starts nothing
   wire go_erase = wr_ctrl & pwdata[CTL_ERASE_GO] & erase_en_q & ~busy; // RL3 RL24
   wire go_write = wr_ctrl & pwdata[CTL_WRITE_GO] & write_en_q & ~busy & ~go_erase; // RL6 RL24
   wire go_read = wr_ctrl & pwdata[CTL_READ_GO] & read_en_q & ~busy & ~go_erase &
      ~go_write; // RL8 RL9 RL24
   wire inhibit = is_erase_q ? ~erase_en_q : ~write_en_q;

   // Sequencer
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         state_q <= ST_IDLE;
         timer_q <= '0;
         idx_q <= 4'h0;
         is_erase_q <= 1'b0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (go_erase || go_write) begin
                  state_q <= ST_TIMING;
                  is_erase_q <= go_erase;
                  timer_q <= pick_cycles(go_erase, time_sel_q); // RL1 RL2 RL18
               end else if (go_read) begin
                  state_q <= ST_READ_REQ;
               end
            end
            ST_READ_REQ: state_q <= ST_READ_DONE;
            ST_READ_DONE: state_q <= ST_IDLE;
            ST_TIMING: begin
               if (inhibit) begin
                  state_q <= ST_IDLE; // RL3 RL6
               end else if (timer_q == 32'h0000_0000) begin
                  state_q <= ST_COMMIT;
                  idx_q <= 4'h0;
               end else begin
                  timer_q <= timer_q - 32'h0000_0001; // RL18
               end
            end
            ST_COMMIT: begin
               if (!mode_q || idx_q == LOW_NIBBLE_MAX) begin
                  state_q <= ST_FINISH;
               end else begin
                  idx_q <= idx_q + 4'h1;
               end
            end
            ST_FINISH: state_q <= ST_IDLE;
         endcase
      end
   end

   // Array port: page commits walk all 16 slots, writing only tagged ones
   always_comb begin
      arr_addr = {addr_high_q, addr_low_q}; // RL23
      arr_we = 1'b0;
      arr_wdata = 8'h00;
      if (state_q == ST_COMMIT) begin
         if (mode_q) begin
            arr_addr = {addr_high_q, addr_low_q[7:4], idx_q}; // RL5 RL13
            arr_we = tag_q[idx_q]; // RL15
            arr_wdata = is_erase_q ? 8'h00 : page_buf_q[idx_q]; // RL17
         end else begin
            arr_we = 1'b1;
            arr_wdata = is_erase_q ? 8'h00 : data_q; // RL22
         end
      end
   end

   eeprom_array u_array (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .addr(arr_addr),
      .we(arr_we),
      .wdata(arr_wdata),
      .rdata_q(arr_rdata)
   );

   // Control register; hardware clears come last so they win
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         time_sel_q <= 1'b0;
         mode_q <= 1'b0;
         erase_en_q <= 1'b0;
         erase_go_q <= 1'b0;
         write_en_q <= 1'b0;
         write_go_q <= 1'b0;
         read_en_q <= 1'b0;
         read_go_q <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            time_sel_q <= pwdata[CTL_TIME_SEL];
            mode_q <= pwdata[CTL_MODE]; // RL5
            erase_en_q <= pwdata[CTL_ERASE_EN];
            write_en_q <= pwdata[CTL_WRITE_EN];
            read_en_q <= pwdata[CTL_READ_EN];
         end
         erase_go_q <= erase_go_q | go_erase; // RL3
         write_go_q <= write_go_q | go_write; // RL6
         read_go_q <= read_go_q | go_read; // RL8
         if (state_q == ST_READ_DONE) begin
            read_go_q <= 1'b0; // RL8 RL12
         end
         if (state_q == ST_TIMING && inhibit) begin
            erase_go_q <= 1'b0;
            write_go_q <= 1'b0;
         end
         if (state_q == ST_FINISH) begin
            if (is_erase_q) begin
               erase_go_q <= 1'b0; // RL4
               erase_en_q <= 1'b0; // RL4
            end else begin
               write_go_q <= 1'b0; // RL7
               write_en_q <= 1'b0; // RL7
            end
         end
      end
   end

   // Data register holds a read result until the next read or write
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         data_q <= DATA_RST;
      end else if (state_q == ST_READ_DONE) begin
         data_q <= arr_rdata; // RL11 RL12
      end else if (wr_data) begin
         data_q <= pwdata[7:0];
      end
   end

   // Address pair; only the low nibble ever moves, and it stops at F
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         addr_low_q <= ADDR_LOW_RST; // RL23
         addr_high_q <= ADDR_HIGH_RST; // RL23
      end else begin
         if (wr_alow) begin
            addr_low_q <= pwdata[7:0];
         end
         if (wr_ahigh) begin
            addr_high_q <= pwdata[1:0];
         end
         if (mode_q && (state_q == ST_READ_DONE || (wr_data && !busy))) begin
            addr_low_q[3:0] <= sat_inc(addr_low_q[3:0]); // RL12 RL13 RL15
         end
      end
   end

   // Page buffer and address tags; a falling erase or write enable empties them
   always_ff @(posedge ref_clk) begin
      erase_en_prev_q <= rstn & erase_en_q;
      write_en_prev_q <= rstn & write_en_q;
      if (!rstn || (erase_en_prev_q && !erase_en_q) || (write_en_prev_q && !write_en_q)) begin
         tag_q <= 16'h0000; // RL14
         for (int i = 0; i < PAGE_BYTES; i++) begin
            page_buf_q[i] <= 8'h00; // RL14
         end
      end else if (wr_data && mode_q && !busy) begin
         tag_q[addr_low_q[3:0]] <= 1'b1; // RL15
         page_buf_q[addr_low_q[3:0]] <= pwdata[7:0];
      end
   end

   // Completion flag: set wins over a same-cycle software clear
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         flag_q <= 1'b0;
      end else if (state_q == ST_FINISH) begin
         flag_q <= 1'b1; // RL21 RL18
      end else if (wr_sts && pwdata[STS_DONE]) begin
         flag_q <= 1'b0; // RL21
      end
   end

   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (paddr)
         OFS_DATA: rd_word[7:0] = data_q;
         OFS_CTRL: rd_word[7:0] = {time_sel_q, erase_en_q, erase_go_q, mode_q,
            write_en_q, write_go_q, read_en_q, read_go_q};
         OFS_ADDR_LOW: rd_word[7:0] = addr_low_q;
         OFS_ADDR_HIGH: rd_word[1:0] = addr_high_q;
         OFS_STATUS: begin
            rd_word[STS_DONE] = flag_q;
            rd_word[STS_BUSY] = busy;
         end
         default: rd_word = 32'h0000_0000;
      endcase
   end

   // One wait state buys registered read data and error
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= psel & penable & ~pready_q;
         if (psel && penable && !pready_q) begin
            prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
            pslverr_q <= ~mapped(paddr);
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign completion_irq_flag = flag_q;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);

   cycle_time0_a: assert property ( // RL1
      (go_erase || go_write) && !time_sel_q |=>
      timer_q == ($past(go_erase) ? 32'(ERASE_CYC0 - 1) : 32'(WRITE_CYC0 - 1)))
      else $error("cycle time wrong with select low");
   cycle_time1_a: assert property ( // RL2
      (go_erase || go_write) && time_sel_q |=>
      timer_q == ($past(go_erase) ? 32'(ERASE_CYC1 - 1) : 32'(WRITE_CYC1 - 1)))
      else $error("cycle time wrong with select high");
   erase_gate_a: assert property ( // RL3
      wr_ctrl && pwdata[CTL_ERASE_GO] && !erase_en_q && !erase_go_q |=> !erase_go_q)
      else $error("erase started without enable");
   erase_done_a: assert property ( // RL4
      state_q == ST_FINISH && is_erase_q |=> !erase_go_q && !erase_en_q)
      else $error("erase bits not cleared at end");
   write_gate_a: assert property ( // RL6
      wr_ctrl && pwdata[CTL_WRITE_GO] && !write_en_q && !write_go_q |=> !write_go_q)
      else $error("write started without enable");
   write_done_a: assert property ( // RL7
      state_q == ST_FINISH && !is_erase_q |=> !write_go_q && !write_en_q)
      else $error("write bits not cleared at end");
   read_clear_a: assert property ( // RL8
      $rose(read_go_q) |-> read_go_q ##1 read_go_q ##1 (!read_go_q && state_q == ST_IDLE))
      else $error("read start not cleared after two cycles");
   page_saturate_a: assert property ( // RL13
      state_q == ST_READ_DONE && mode_q && !wr_alow |=>
      addr_low_q[3:0] == (($past(addr_low_q[3:0]) == 4'hF) ? 4'hF :
      4'($past(addr_low_q[3:0]) + 4'h1)) && $stable(addr_low_q[7:4]))
      else $error("page address step wrong");
   buffer_clear_a: assert property ( // RL14
      $fell(erase_en_q) |=> tag_q == 16'h0000)
      else $error("page buffer not cleared on enable fall");
   flag_set_a: assert property ( // RL21
      state_q == ST_FINISH |=> flag_q)
      else $error("completion flag not set");
   busy_ignore_a: assert property ( // RL24
      busy && wr_ctrl && pwdata[CTL_READ_GO] && !read_go_q |=> !read_go_q)
      else $error("read started while busy");
endmodule : data_eeprom_access_control

/* eeprom_array.sv */
// Purpose: 1024 x 8 storage array with one port and registered read data.
// Assumes: Write and read share the address; read data appears one cycle later.
// Notes: Contents are not reset, as a non-volatile array would keep them.
`timescale 1ns/1ns
module eeprom_array (
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rstn,
   // Access port
   input wire logic [eeprom_pkg::ADDR_W-1:0] addr,
   input wire logic we,
   input wire logic [7:0] wdata,
   output logic [7:0] rdata_q
);
   import eeprom_pkg::*;

   logic [7:0] mem [2**ADDR_W];

   always_ff @(posedge ref_clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rdata_q <= DATA_RST;
      end else begin
         rdata_q <= mem[addr];
      end
   end
endmodule : eeprom_array

/* eeprom_pkg.sv */
// Purpose: Shared constants and types for the data EEPROM access control block.
// Assumes: 100 MHz ref_clk, APB register access with 32-bit data.
// Notes: Register offsets are byte addresses; each register takes one aligned word.
package eeprom_pkg;
   // Array geometry
   localparam int unsigned ADDR_W = 10;
   localparam int unsigned PAGE_BYTES = 16;
   localparam logic [3:0] LOW_NIBBLE_MAX = 4'hF;

   // Register byte offsets
   localparam logic [11:0] OFS_DATA = 12'h000;
   localparam logic [11:0] OFS_CTRL = 12'h004;
   localparam logic [11:0] OFS_ADDR_LOW = 12'h008;
   localparam logic [11:0] OFS_ADDR_HIGH = 12'h00C;
   localparam logic [11:0] OFS_STATUS = 12'h010;

   // Control register field positions
   localparam int unsigned CTL_TIME_SEL = 7;
   localparam int unsigned CTL_ERASE_EN = 6;
   localparam int unsigned CTL_ERASE_GO = 5;
   localparam int unsigned CTL_MODE = 4;
   localparam int unsigned CTL_WRITE_EN = 3;
   localparam int unsigned CTL_WRITE_GO = 2;
   localparam int unsigned CTL_READ_EN = 1;
   localparam int unsigned CTL_READ_GO = 0;

   // Status register field positions
   localparam int unsigned STS_DONE = 0;
   localparam int unsigned STS_BUSY = 1;

   // Reset values
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [7:0] ADDR_LOW_RST = 8'h00;
   localparam logic [1:0] ADDR_HIGH_RST = 2'h0;

   // Cycle times
   localparam real CLK_PERIOD_NS = 10.0;
   localparam real ERASE_TIME0_MS = 3.2;
   localparam real WRITE_TIME0_MS = 2.2;
   localparam real ERASE_TIME1_MS = 3.7;
   localparam real WRITE_TIME1_MS = 3.0;
   localparam int unsigned ERASE_CYC0 = int'(ERASE_TIME0_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned WRITE_CYC0 = int'(WRITE_TIME0_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned ERASE_CYC1 = int'(ERASE_TIME1_MS * 1.0e6 / CLK_PERIOD_NS);
   localparam int unsigned WRITE_CYC1 = int'(WRITE_TIME1_MS * 1.0e6 / CLK_PERIOD_NS);

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_READ_REQ,
      ST_READ_DONE,
      ST_TIMING,
      ST_COMMIT,
      ST_FINISH
   } state_type;
endpackage : eeprom_pkg

/* tb_top.sv */
// Purpose: Self-checking bench for the data EEPROM access control block over APB.
// Assumes: Short cycle parameters; one wait state per APB access as the note gives.
// Notes: Array model is filled only where the bench wrote, so only those bytes are read.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin err_count++; \
   $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); end end
module tb_top;
   import eeprom_pkg::*;
   localparam int unsigned EC0 = 20;
   localparam int unsigned WC0 = 10;
   localparam int unsigned EC1 = 30;
   localparam int unsigned WC1 = 15;
   logic ref_clk = 1'b0;
   logic rstn = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hF;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic completion_irq_flag;
   int err_count = 0;
   int checked = 0;
   int cyc = 0;
   logic [31:0] seed = 32'h3394;
   logic [31:0] rv;
   logic er;
   logic [7:0] v;
   logic [7:0] mem [0:1023];
   logic [5:0] pg;
   logic [9:0] a;
   logic [11:0] offs [5] = '{OFS_DATA, OFS_CTRL, OFS_ADDR_LOW, OFS_ADDR_HIGH, OFS_STATUS};
   logic [7:0] gos [3] = '{8'h20, 8'h04, 8'h01};

   data_eeprom_access_control #(.ERASE_CYC0(EC0), .WRITE_CYC0(WC0), .ERASE_CYC1(EC1),
      .WRITE_CYC1(WC1)) u_dut (.ref_clk(ref_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .completion_irq_flag(completion_irq_flag));

   initial begin
      forever #5 ref_clk = ~ref_clk;
   end

   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr_next

   task print_verdict;
      if (err_count == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask : print_verdict

   // Request held until pready is sampled high, released only after that edge
   task apb(input logic wr, input logic [11:0] ad, input logic [31:0] d,
            output logic [31:0] r, output logic e);
      int n;
      @(posedge ref_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= ad;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      `CHK("apb_ready", 1'b1, pready)
   endtask : apb

   task wr(input logic [11:0] ad, input logic [7:0] d);
      apb(1'b1, ad, {24'h0, d}, rv, er);
      `CHK("slverr_write", 1'b0, er)
   endtask : wr

   task rd(input logic [11:0] ad, output logic [7:0] d);
      apb(1'b0, ad, 32'h0, rv, er);
      `CHK("slverr_read", 1'b0, er)
      d = rv[7:0];
   endtask : rd

   task set_addr(input logic [9:0] ad);
      wr(OFS_ADDR_HIGH, {6'h0, ad[9:8]});
      wr(OFS_ADDR_LOW, ad[7:0]);
   endtask : set_addr

   // Read enable is kept set, so the second write sets only the start bit
   task rd_byte(input logic [7:0] base, output logic [7:0] d);
      int n;
      logic [7:0] c;
      wr(OFS_CTRL, base | 8'h02);
      wr(OFS_CTRL, base | 8'h03);
      n = 0;
      do begin
         rd(OFS_CTRL, c);
         n++;
      end while (c[0] !== 1'b0 && n < 20);
      `CHK("read_start_clr", 1'b0, c[0])
      rd(OFS_DATA, d);
   endtask : rd_byte

   task run_op(input logic [7:0] en, input logic [7:0] go, input int lo, input int hi);
      int t0;
      logic [7:0] c;
      // Enable and start go out back to back, nothing may slip in between
      wr(OFS_CTRL, en);
      wr(OFS_CTRL, go);
      t0 = cyc;
      // Read start poked mid-cycle must be dropped
      wr(OFS_CTRL, go | 8'h01);
      rd(OFS_CTRL, c);
      `CHK("busy_ignore", go, c)
      while (completion_irq_flag !== 1'b1 && cyc - t0 < 2000) begin
         @(posedge ref_clk);
      end
      `CHK("cycle_len_lo", 1'b1, cyc - t0 >= lo)
      `CHK("cycle_len_hi", 1'b1, cyc - t0 <= hi)
      rd(OFS_CTRL, c);
      `CHK("ctrl_after", en & 8'h92, c)
      rd(OFS_STATUS, c);
      `CHK("flag_set", 8'h01, c)
      wr(OFS_STATUS, 8'h01);
      rd(OFS_STATUS, c);
      `CHK("flag_clr", 8'h00, c)
   endtask : run_op

   // Five page reads from slot C: the last two both land on slot F
   task check_page;
      int i;
      for (i = 0; i < 5; i++) begin
         rd_byte(8'h10, v);
         `CHK("page_read", mem[{pg, 4'hC + 4'(i > 3 ? 3 : i)}], v)
         rd(OFS_ADDR_LOW, v);
         `CHK("page_addr", {pg[3:0], 4'hC + 4'(i > 2 ? 3 : i + 1)}, v)
      end
   endtask : check_page

   initial begin
      repeat (20000) @(posedge ref_clk);
      err_count++;
      print_verdict();
   end

   initial begin
      repeat (20) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      foreach (offs[i]) begin
         rd(offs[i], v);
         `CHK("reset_value", 8'h00, v)
      end
      apb(1'b0, 12'h014, 32'h0, rv, er);
      `CHK("unmapped_err", 1'b1, er)
      `CHK("unmapped_data", 32'h0, rv)
      // A write with byte lane 0 off is dropped
      pstrb <= 4'h0;
      wr(OFS_ADDR_LOW, 8'hFF);
      pstrb <= 4'hF;
      rd(OFS_ADDR_LOW, v);
      `CHK("strobe_off", 8'h00, v)
      // Starts without their enable do nothing
      wr(OFS_DATA, 8'h5A);
      foreach (gos[i]) begin
         wr(OFS_CTRL, gos[i]);
         rd(OFS_CTRL, v);
         `CHK("start_no_enable", 8'h00, v)
         rd(OFS_DATA, v);
         `CHK("data_kept", 8'h5A, v)
      end
      wr(OFS_CTRL, 8'h02);
      for (int ts = 0; ts < 2; ts++) begin
         seed = lfsr_next(seed);
         a = seed[9:0];
         mem[a] = seed[17:10];
         set_addr(a);
         wr(OFS_DATA, mem[a]);
         run_op({ts[0], 7'h0A}, {ts[0], 7'h0E}, ts ? WC1 : WC0, (ts ? WC1 : WC0) + 5);
         rd_byte(8'h00, v);
         `CHK("byte_write", mem[a], v)
         mem[a] = 8'h00;
         run_op({ts[0], 7'h42}, {ts[0], 7'h62}, ts ? EC1 : EC0, (ts ? EC1 : EC0) + 5);
         rd_byte(8'h00, v);
         `CHK("byte_erase", 8'h00, v)
      end
      // Page write of slots C..F, then erase of slot D only
      seed = lfsr_next(seed);
      pg = seed[5:0];
      wr(OFS_CTRL, 8'h12);
      set_addr({pg, 4'hC});
      for (int i = 0; i < 4; i++) begin
         seed = lfsr_next(seed);
         mem[{pg, 4'hC + 4'(i)}] = seed[7:0];
         wr(OFS_DATA, seed[7:0]);
      end
      rd(OFS_ADDR_LOW, v);
      `CHK("page_saturate", {pg[3:0], 4'hF}, v)
      run_op(8'h1A, 8'h1E, WC0 + 15, WC0 + 21);
      set_addr({pg, 4'hC});
      check_page();
      wr(OFS_CTRL, 8'h52);
      set_addr({pg, 4'hC});
      wr(OFS_DATA, 8'hA5);
      // Enable fall drops the tag on slot C
      wr(OFS_CTRL, 8'h12);
      wr(OFS_DATA, 8'h3C);
      mem[{pg, 4'hD}] = 8'h00;
      run_op(8'h52, 8'h72, EC0 + 15, EC0 + 21);
      set_addr({pg, 4'hC});
      check_page();
      print_verdict();
   end
endmodule : tb_top
